// ===== rtl/ir_carrier_pkg.sv
// constants and register map of the infrared carrier generator
`default_nettype none
package ir_carrier_pkg;
  localparam int          MOD_W            = 9;
  localparam int          TICK_CLOCKS      = 64;
  localparam logic [4:0]  ADDR_LOW_LOW     = 5'h00;
  localparam logic [4:0]  ADDR_LOW_HIGH    = 5'h04;
  localparam logic [4:0]  ADDR_HIGH_LOW    = 5'h08;
  localparam logic [4:0]  ADDR_HIGH_HIGH   = 5'h0c;
  localparam logic [4:0]  ADDR_TIMER_LOW   = 5'h10;
  localparam logic [4:0]  ADDR_TIMER_UPPER = 5'h14;
  localparam logic [7:0]  LOW_LOW_RESET    = 8'h08;
  localparam logic [7:0]  HIGH_LOW_RESET   = 8'h08;
  localparam logic        INHIBIT_RESET    = 1'b1;
  localparam int          BIT_EIGHT_POS    = 0;
  localparam int          INHIBIT_POS      = 1;
  localparam int          TIMER_EN_POS     = 1;
  localparam int          PIN_SEL_POS      = 6;
  localparam int          END_FLAG_POS     = 7;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_LOW  = 2'b01,
    PH_HIGH = 2'b10
  } phase_e;
endpackage
`default_nettype wire

// ===== rtl/carrier_phase_counter.sv
// 9-bit carrier phase counter alternating low and high periods
`default_nettype none
module carrier_phase_counter
  import ir_carrier_pkg::*;
#(
  parameter int W = ir_carrier_pkg::MOD_W
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         run,
  input  wire logic [W-1:0] low_phase_modulo,
  input  wire logic [W-1:0] high_phase_modulo,
  output logic              carrier
);
  typedef struct packed {
    phase_e       phase;
    logic [W-1:0] count;
  } state_s;
  state_s cur;
  state_s next_cur;

  always_comb begin
    next_cur = cur;
    case (cur.phase)
      PH_IDLE: begin
        if (run) begin
          next_cur.phase = PH_LOW; // [RULE11]
          next_cur.count = low_phase_modulo;
        end
      end
      PH_LOW: begin
        if (cur.count == '0) begin
          next_cur.phase = PH_HIGH; // [RULE7] [RULE18]
          next_cur.count = high_phase_modulo;
        end else begin
          next_cur.count = cur.count - 1'b1;
        end
      end
      PH_HIGH: begin
        if (cur.count == '0) begin
          next_cur.phase = PH_LOW; // [RULE7] [RULE18]
          next_cur.count = low_phase_modulo;
        end else begin
          next_cur.count = cur.count - 1'b1;
        end
      end
      default: next_cur.phase = PH_IDLE;
    endcase
    if (!run) begin
      next_cur.phase = PH_IDLE; // [RULE18]
      next_cur.count = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '{phase: PH_IDLE, count: '0};
    end else begin
      cur <= next_cur;
    end
  end

  assign carrier = (cur.phase == PH_HIGH); // [RULE1]
endmodule
`default_nettype wire

// ===== rtl/ir_carrier_generator.sv
// infrared carrier generator with down timer gate and AXI4-Lite registers
// Notes on behaviour
// [RULE1] carrier comes from a 9-bit counter and high and low modulo values
// [RULE2] low modulo bit 8 is read/write bit 0 of upper low register
// [RULE3] low modulo bit 9 reads zero; upper bits 7..2 read zero
// [RULE4] high modulo bit 8 is bit 0 of upper high register
// [RULE5] inhibit bit, bit 1 of upper high register, resets to 1, stops carrier
// [RULE6] software clears inhibit after writing both modulo values
// [RULE7] low phase lasts low+1 clocks, high phase high+1 clocks
// [RULE8] software keeps modulo values between 001h and 1ffh
// [RULE9] software writes modulo values before enabling the timer
// [RULE10] software changes modulo values only while pin is inactive
// [RULE11] each carrier start begins with the low phase
// [RULE12] after reset pin is open-drain function, floating; bit 6 selects
// [RULE13] not inhibited: carrier while counter nonzero, one tick when zero
// [RULE14] inhibited and enabled: push-pull high, open-drain low
// [RULE15] timer output reaches pin only while timer enable is set
// [RULE16] down counter drops every 64 clocks, stops at zero, sets end flag
// [RULE17] select bit 0 is open-drain function, 1 is push-pull
// [RULE18] carrier counter reloads per phase, idles while gated off
`default_nettype none
module ir_carrier_generator
  import ir_carrier_pkg::*;
#(
  parameter int TICK = ir_carrier_pkg::TICK_CLOCKS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             push_pull_carrier_pin,
  output logic             push_pull_carrier_pin_oe,
  output logic             open_drain_driver_pin,
  output logic             open_drain_driver_pin_oe
);
  localparam int DIV_W = $clog2(TICK);

  typedef struct packed {
    logic             aw_held;
    logic [4:0]       aw_addr;
    logic             w_held;
    logic [31:0]      w_data;
    logic             w_lane0;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [7:0]       low_modulo_low_byte;
    logic             low_modulo_bit_eight;
    logic [7:0]       high_modulo_low_byte;
    logic             high_modulo_bit_eight;
    logic             carrier_inhibit;
    logic [7:0]       timer_low_byte;
    logic             timer_bit_eight;
    logic             timer_output_enable;
    logic             pin_select;
    logic             timer_end_flag;
    logic [MOD_W-1:0] down_count;
    logic             counting;
    logic             last_tick;
    logic [DIV_W-1:0] div;
    logic             pin_level;
  } state_s;

  state_s cur;
  state_s next_cur;
  logic   carrier;
  logic   run;
  logic   wr_fire;
  logic   rd_fire;

  assign s_axi_awready = !cur.aw_held && !cur.bvalid;
  assign s_axi_wready  = !cur.w_held && !cur.bvalid;
  assign s_axi_arready = !cur.rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign wr_fire       = (cur.aw_held || (s_axi_awvalid && s_axi_awready)) &&
                         (cur.w_held || (s_axi_wvalid && s_axi_wready)) && !cur.bvalid;

  // carrier runs only while enabled, not inhibited, and timer still active
  assign run = cur.timer_output_enable && !cur.carrier_inhibit &&
               (cur.counting || cur.last_tick); // [RULE13] [RULE5]

  always_comb begin
    logic [4:0]  waddr;
    logic [31:0] wdata;
    logic        wlane;
    logic        tick;
    waddr = cur.aw_held ? cur.aw_addr : s_axi_awaddr;
    wdata = cur.w_held ? cur.w_data : s_axi_wdata;
    wlane = cur.w_held ? cur.w_lane0 : s_axi_wstrb[0];
    tick  = (cur.div == DIV_W'(TICK - 1));
    next_cur = cur;

    // write channels may arrive in either order
    if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
      next_cur.aw_held = 1'b1;
      next_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
      next_cur.w_held  = 1'b1;
      next_cur.w_data  = s_axi_wdata;
      next_cur.w_lane0 = s_axi_wstrb[0];
    end
    if (cur.bvalid && s_axi_bready) begin
      next_cur.bvalid = 1'b0;
    end
    if (cur.rvalid && s_axi_rready) begin
      next_cur.rvalid = 1'b0;
    end

    // down timer: one step per 64 clocks, stop at zero, flag one step later
    if (cur.counting || cur.last_tick) begin
      next_cur.div = cur.div + 1'b1;
      if (tick) begin
        next_cur.div = '0;
        if (cur.last_tick) begin
          next_cur.last_tick      = 1'b0;
          next_cur.timer_end_flag = 1'b1; // [RULE16]
        end else if (cur.down_count == 9'h001) begin
          // reaching zero still owes one interval, so a value n runs n+1 steps
          next_cur.down_count = '0;
          next_cur.counting   = 1'b0;
          next_cur.last_tick  = 1'b1; // [RULE13] [RULE16]
        end else begin
          next_cur.down_count = cur.down_count - 1'b1; // [RULE16]
        end
      end
    end

    if (wr_fire) begin
      next_cur.aw_held = 1'b0;
      next_cur.w_held  = 1'b0;
      next_cur.bvalid  = 1'b1;
      next_cur.bresp   = RESP_OKAY;
      if (wlane) begin
        case (waddr)
          ADDR_LOW_LOW:   next_cur.low_modulo_low_byte = wdata[7:0];
          ADDR_LOW_HIGH:  next_cur.low_modulo_bit_eight = wdata[BIT_EIGHT_POS]; // [RULE2]
          ADDR_HIGH_LOW:  next_cur.high_modulo_low_byte = wdata[7:0];
          ADDR_HIGH_HIGH: begin
            next_cur.high_modulo_bit_eight = wdata[BIT_EIGHT_POS]; // [RULE4]
            next_cur.carrier_inhibit       = wdata[INHIBIT_POS]; // [RULE5]
          end
          ADDR_TIMER_LOW: next_cur.timer_low_byte = wdata[7:0];
          ADDR_TIMER_UPPER: begin
            // upper write loads the whole 9-bit value into the down counter
            next_cur.timer_bit_eight     = wdata[BIT_EIGHT_POS];
            next_cur.down_count          = {wdata[BIT_EIGHT_POS], cur.timer_low_byte};
            next_cur.timer_end_flag      = 1'b0;
            next_cur.counting            = 1'b0;
            next_cur.last_tick           = 1'b0;
            next_cur.div                 = '0;
            next_cur.pin_select          = wdata[PIN_SEL_POS]; // [RULE17]
            next_cur.timer_output_enable = wdata[TIMER_EN_POS]; // [RULE15]
            if (wdata[TIMER_EN_POS]) begin
              // start always from the written value; zero gives one step
              next_cur.counting  = ({wdata[BIT_EIGHT_POS], cur.timer_low_byte} != '0);
              next_cur.last_tick = ({wdata[BIT_EIGHT_POS], cur.timer_low_byte} == '0);
            end
          end
          default: next_cur.bresp = RESP_SLVERR;
        endcase
      end
    end

    if (rd_fire) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp  = RESP_OKAY;
      next_cur.rdata  = '0;
      case (s_axi_araddr)
        ADDR_LOW_LOW:   next_cur.rdata[7:0] = cur.low_modulo_low_byte;
        ADDR_LOW_HIGH:  next_cur.rdata[BIT_EIGHT_POS] = cur.low_modulo_bit_eight; // [RULE3]
        ADDR_HIGH_LOW:  next_cur.rdata[7:0] = cur.high_modulo_low_byte;
        ADDR_HIGH_HIGH: begin
          next_cur.rdata[BIT_EIGHT_POS] = cur.high_modulo_bit_eight;
          next_cur.rdata[INHIBIT_POS]   = cur.carrier_inhibit;
        end
        ADDR_TIMER_LOW: next_cur.rdata[7:0] = cur.down_count[7:0];
        ADDR_TIMER_UPPER: begin
          next_cur.rdata[BIT_EIGHT_POS] = cur.down_count[8];
          next_cur.rdata[TIMER_EN_POS]  = cur.timer_output_enable;
          next_cur.rdata[PIN_SEL_POS]   = cur.pin_select;
          next_cur.rdata[END_FLAG_POS]  = cur.timer_end_flag;
        end
        default: next_cur.rresp = RESP_SLVERR;
      endcase
    end

    // registered pin level
    if (!cur.timer_output_enable) begin
      next_cur.pin_level = 1'b0; // [RULE13] [RULE14]
    end else if (cur.carrier_inhibit) begin
      next_cur.pin_level = 1'b1; // [RULE14]
    end else begin
      next_cur.pin_level = run && carrier; // [RULE13] [RULE15]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur                      <= '0;
      cur.low_modulo_low_byte  <= LOW_LOW_RESET;
      cur.high_modulo_low_byte <= HIGH_LOW_RESET;
      cur.carrier_inhibit      <= INHIBIT_RESET; // [RULE5]
      cur.pin_select           <= 1'b0; // [RULE12]
    end else begin
      cur <= next_cur;
    end
  end

  carrier_phase_counter #(
    .W (MOD_W)
  ) u_phase (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .run               (run),
    .low_phase_modulo  ({cur.low_modulo_bit_eight, cur.low_modulo_low_byte}),
    .high_phase_modulo ({cur.high_modulo_bit_eight, cur.high_modulo_low_byte}),
    .carrier           (carrier)
  );

  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp  = cur.bresp;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata  = cur.rdata;
  assign s_axi_rresp  = cur.rresp;

  // only one function drives at a time; open-drain pulls low when active
  assign push_pull_carrier_pin    = cur.pin_level;
  assign push_pull_carrier_pin_oe = cur.pin_select; // [RULE17]
  assign open_drain_driver_pin    = 1'b0;
  assign open_drain_driver_pin_oe = !cur.pin_select && cur.pin_level; // [RULE12] [RULE17]
endmodule
`default_nettype wire

// ===== tb/ir_carrier_checker.sv
// port checker for the infrared carrier generator
`default_nettype none
module ir_carrier_checker import ir_carrier_pkg::*; #(
  parameter int TICK = 64
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [4:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        push_pull_carrier_pin_oe,
  input wire logic        open_drain_driver_pin,
  input wire logic        open_drain_driver_pin_oe
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_rst;
    $rose(aresetn) |-> !push_pull_carrier_pin_oe && !open_drain_driver_pin_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("pin driven after reset");
  property p_od_low;
    open_drain_driver_pin == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open-drain data high");
  property p_one_drv;
    !(push_pull_carrier_pin_oe && open_drain_driver_pin_oe);
  endproperty
  a_one_drv: assert property (p_one_drv) else $error("both pin functions on");
  property p_wr_ans;
    s_wr |=> s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
  property p_wr_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write taken while answering");
  property p_b_cause;
    $rose(s_axi_bvalid) |-> $past(s_axi_awvalid || s_axi_wvalid);
  endproperty
  a_b_cause: assert property (p_b_cause) else $error("answer without write");
  property p_rd_ans;
    s_rd |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  property p_low_up;
    s_rd ##0 (s_axi_araddr == ADDR_LOW_HIGH) |=> s_axi_rdata[31:1] == '0;
  endproperty
  a_low_up: assert property (p_low_up) else $error("low upper bits not zero");
  property p_high_up;
    s_rd ##0 (s_axi_araddr == ADDR_HIGH_HIGH) |=> s_axi_rdata[31:2] == '0;
  endproperty
  a_high_up: assert property (p_high_up) else $error("high upper bits not zero");
endmodule
bind ir_carrier_generator ir_carrier_checker #(.TICK(TICK)) u_chk (.*);
`default_nettype wire

// ===== tb/ir_led_model.sv
// infrared emitter model hanging on the carrier pins
`default_nettype none
module ir_led_model (
  input  wire logic pp,
  input  wire logic pp_oe,
  input  wire logic od,
  input  wire logic od_oe,
  output logic      line,
  output logic      emit
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up holds the released open-drain node high, never a stale level
  assign line = od_oe ? od : 1'b1;
  assign emit = pp_oe ? pp : !line;
endmodule
`default_nettype wire

// ===== tb/ir_carrier_generator_tb_top.sv
// self-checking bench of the infrared carrier generator
`default_nettype none
module ir_carrier_generator_tb_top import ir_carrier_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 4; // short tick keeps timer runs brief
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic [4:0]  awaddr = '0;
  logic [4:0]  araddr = '0;
  logic [4:0]  a;
  logic [31:0] wdata = '0;
  logic [31:0] d;
  logic [31:0] rdata;
  logic [1:0]  bresp, rresp, rsp;
  logic [8:0]  lo, hi;
  logic        awready, wready, bvalid, arready, rvalid, pp, pp_oe, od, od_oe, line, emit;
  int          err_count = 0;
  int          checks = 0;
  int          seed = 32'h7732;
  int          i, k, n, h, l;
  time         t0;
  ir_carrier_generator #(.TICK(T)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .push_pull_carrier_pin(pp),
    .push_pull_carrier_pin_oe(pp_oe), .open_drain_driver_pin(od),
    .open_drain_driver_pin_oe(od_oe)
  );
  ir_led_model led (.pp(pp), .pp_oe(pp_oe), .od(od), .od_oe(od_oe), .line(line), .emit(emit));
  initial forever #10 aclk = ~aclk;
  task automatic end_of_test();
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int c);
    if (c >= 2000) begin
      err_count++;
      end_of_test();
    end
  endtask
  // valids drop only when taken; a new request may start at the answer edge
  task automatic wr(input logic [4:0] ad, input logic [31:0] v);
    awaddr <= ad;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 2000; i++) begin
      @(posedge aclk);
      if (bvalid) break;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    rsp = bresp;
    tmo(i);
  endtask
  task automatic rd(input logic [4:0] ad);
    araddr <= ad;
    arvalid <= 1'b1;
    for (i = 0; i < 2000; i++) begin
      @(posedge aclk);
      if (rvalid) break;
      if (arready) arvalid <= 1'b0;
    end
    d = rdata;
    rsp = rresp;
    tmo(i);
  endtask
  task automatic rchk(input logic [4:0] ad, input logic [31:0] e);
    rd(ad);
    chk(d, e);
  endtask
  task automatic run_len(input logic v, output int c);
    for (c = 0; c < 2000; c++) begin
      @(posedge aclk);
      if (emit !== v) break;
    end
    tmo(c);
  endtask
  function automatic logic [31:0] rb(input logic [4:0] ad, input logic [31:0] v);
    case (ad)
      ADDR_LOW_HIGH:  rb = v & 32'h1;
      ADDR_HIGH_HIGH: rb = v & 32'h3;
      default:        rb = v & 32'hff;
    endcase
  endfunction
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk({pp_oe, od_oe, line}, 3'b001);
    rchk(ADDR_LOW_LOW, 32'h08);
    rchk(ADDR_LOW_HIGH, 32'h0);
    rchk(ADDR_HIGH_LOW, 32'h08);
    rchk(ADDR_HIGH_HIGH, 32'h2);
    rchk(ADDR_TIMER_UPPER, 32'h0);
    for (k = 0; k < 8; k++) begin
      a = 5'(($random(seed) & 3) << 2);
      d = $random(seed);
      wr(a, d);
      rchk(a, rb(a, d));
    end
    wr(5'h18, 32'hff);
    chk(rsp, RESP_SLVERR);
    rchk(5'h1c, 32'h0);
    chk(rsp, RESP_SLVERR);
    for (k = 0; k < 3; k++) begin
      lo = (k == 0) ? 9'h1 : (k == 1) ? 9'h100 : 9'(1 + ($random(seed) & 63));
      hi = (k == 0) ? 9'h1 : (k == 1) ? 9'h1ff : 9'(1 + ($random(seed) & 63));
      wr(ADDR_TIMER_UPPER, 32'h40); // pin idle before the modulo change
      wr(ADDR_LOW_LOW, 32'(lo[7:0]));
      wr(ADDR_LOW_HIGH, 32'(lo[8]));
      wr(ADDR_HIGH_LOW, 32'(hi[7:0]));
      wr(ADDR_HIGH_HIGH, 32'(hi[8])); // inhibit cleared last
      wr(ADDR_TIMER_LOW, 32'hff);
      wr(ADDR_TIMER_UPPER, 32'h43);
      run_len(1'b0, n);
      run_len(1'b1, h);
      run_len(1'b0, l);
      chk(n >= lo + 1 && n <= lo + 4, 1);
      chk(h, hi);
      chk(l, lo);
    end
    for (k = 0; k < 2; k++) begin
      n = k * (1 + ($random(seed) & 7));
      wr(ADDR_TIMER_UPPER, 32'h40);
      wr(ADDR_TIMER_LOW, 32'(n));
      wr(ADDR_TIMER_UPPER, 32'h42);
      t0 = $time;
      for (l = 0; l < 99; l++) begin
        rd(ADDR_TIMER_UPPER);
        if (d[7]) break;
      end
      h = int'(($time - t0) / 20);
      chk(h >= (n + 1) * T - 1 && h <= (n + 1) * T + 5, 1);
      chk(d, 32'hc2);
      rchk(ADDR_TIMER_LOW, 32'h0);
      chk(pp, 1'b0);
    end
    wr(ADDR_TIMER_UPPER, 32'h40);
    repeat (4) @(posedge aclk);
    chk({pp_oe, od_oe, emit}, 3'b100);
    wr(ADDR_HIGH_HIGH, 32'h2);
    wr(ADDR_TIMER_UPPER, 32'h42);
    repeat (4) @(posedge aclk);
    chk({pp_oe, od_oe, pp}, 3'b101);
    wr(ADDR_TIMER_UPPER, 32'h02);
    repeat (4) @(posedge aclk);
    chk({pp_oe, od_oe, line}, 3'b010);
    wr(ADDR_TIMER_UPPER, 32'h00);
    repeat (4) @(posedge aclk);
    chk({od_oe, line, emit}, 3'b010);
    // reset after the timer is switched off must bring back the power-on register state
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk({pp_oe, od_oe, line}, 3'b001);
    rchk(ADDR_HIGH_HIGH, 32'h2);
    rchk(ADDR_TIMER_UPPER, 32'h0);
    rchk(ADDR_LOW_LOW, 32'h08);
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge aclk);
    err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
